// *** mai_pkg.sv ***
// shared constants and types for the addition datapath
package mai_pkg;

   // ***************************************************
   // widths and register map
   // ***************************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;

   localparam logic [11:0] OFF_CONTROL = 12'h000; // op select, memory address, go
   localparam logic [11:0] OFF_OPERAND = 12'h004; // immediate value
   localparam logic [11:0] OFF_WORKREG = 12'h008; // working register
   localparam logic [11:0] OFF_FLAGS   = 12'h00c; // status flags
   localparam logic [11:0] OFF_MEMWIN  = 12'h010; // data memory window, byte in bits 7:0, index from control memory address bits 3:0
   localparam logic [11:0] OFF_LAST    = 12'h014; // last result and status

   localparam int CTL_OP_LSB   = 0;
   localparam int CTL_ADDR_LSB = 8;
   localparam int CTL_GO_BIT   = 31;

   localparam int FLG_CARRY = 0;
   localparam int FLG_HALF  = 1;
   localparam int FLG_ZERO  = 2;
   localparam int FLG_WRAP  = 3;

   localparam int MEM_DEPTH = 16;
   localparam int MEM_IDX_W = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************
   // operations
   // ***************************************************
   typedef enum logic [1:0] {
      OP_SUM_CARRY_TO_WORK     = 2'h0,
      OP_SUM_WITH_CARRY_TO_MEM = 2'h1,
      OP_SUM_MEM_TO_WORK       = 2'h2,
      OP_SUM_IMM_TO_WORK       = 2'h3
   } mai_op_type;

endpackage : mai_pkg

// *** mai_alu_if.sv ***
// operand and result bundle between control and adder
`timescale 1ns/1ps
interface mai_alu_if;
   logic [7:0] workIn;
   logic [7:0] operandIn;
   logic       carryIn;
   logic       useCarry;
   logic [7:0] sum;
   logic       carryOut;
   logic       halfOut;
   logic       zeroOut;
   logic       wrapOut;

   modport ctrl (output workIn, operandIn, carryIn, useCarry,
                 input sum, carryOut, halfOut, zeroOut, wrapOut);
   modport alu  (input workIn, operandIn, carryIn, useCarry,
                 output sum, carryOut, halfOut, zeroOut, wrapOut);
endinterface : mai_alu_if

// *** mai_adder.sv ***
// 8-bit adder with carry, half-carry, zero and overflow flags
`timescale 1ns/1ps
module mai_adder (
   mai_alu_if.alu bus
);
   logic       cin;
   logic [4:0] lowSum;
   logic [8:0] fullSum;

   // ***************************************************
   // a separate low-nibble add gives the half carry
   // ***************************************************
   always_comb begin
      cin      = bus.useCarry & bus.carryIn;
      lowSum   = {1'b0, bus.workIn[3:0]} + {1'b0, bus.operandIn[3:0]} + {4'h0, cin};
      fullSum  = {1'b0, bus.workIn} + {1'b0, bus.operandIn} + {8'h00, cin};
      bus.sum      = fullSum[7:0];
      bus.carryOut = fullSum[8];
      bus.halfOut  = lowSum[4];
      bus.zeroOut  = (fullSum[7:0] == 8'h00);
      bus.wrapOut  = (bus.workIn[7] == bus.operandIn[7])
                     & (fullSum[7] != bus.workIn[7]);
   end
endmodule : mai_adder

// *** mai_addition.sv ***
// addition datapath top with AXI4-Lite register access
`timescale 1ns/1ps

// How it works
// - carry-sum to working register adds working register, memory byte and carry into the register.
// - carry-sum to memory adds the same three and writes the sum back to that memory byte.
// - memory-operand sum adds the memory byte to the working register without carry.
// - immediate sum adds the instruction constant to the working register without carry.
// - every addition updates exactly the wrap, zero, half-carry and carry flags.
module mai_addition (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      logic                      awHeld;
      logic [11:0]               awAddr;
      logic                      wHeld;
      logic [31:0]               wData;
      logic [3:0]                wStrb;
      logic                      awReady;
      logic                      wReady;
      logic                      bValid;
      logic [1:0]                bResp;
      logic                      arReady;
      logic                      rValid;
      logic [1:0]                rResp;
      logic [31:0]               rData;
      logic [1:0]                op;
      logic [7:0]                memAddr;
      logic [7:0]                immediate;
      logic [7:0]                workReg;
      logic [3:0]                flags;
      logic [7:0]                lastSum;
      logic                      doneSticky;
      logic [16*8-1:0]           mem;
   } mai_state_type;

   mai_state_type state;
   mai_state_type next_state;
   logic          rstMeta;
   logic          rstSync;
   mai_alu_if     alu ();

   // ***************************************************
   // reset release through two flip-flops
   // ***************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   mai_adder u_adder (
      .bus (alu.alu)
   );

   // ***************************************************
   // adder operands from the selected operation
   // ***************************************************
   logic [3:0] memIdx;
   logic [7:0] memByte;
   assign memIdx  = state.memAddr[3:0];
   assign memByte = state.mem[memIdx*8 +: 8];
   assign alu.workIn    = state.workReg;
   assign alu.carryIn   = state.flags[mai_pkg::FLG_CARRY];
   // immediate replaces the memory byte for the constant form
   assign alu.operandIn = (state.op == mai_pkg::OP_SUM_IMM_TO_WORK) ? state.immediate
                                                                   : memByte;
   // only the two carry forms feed the carry flag in
   assign alu.useCarry  = (state.op == mai_pkg::OP_SUM_CARRY_TO_WORK)
                        | (state.op == mai_pkg::OP_SUM_WITH_CARRY_TO_MEM);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ***************************************************
   // bus slave and execution
   // ***************************************************
   always_comb begin
      logic [31:0] cur;
      logic [31:0] val;
      logic        go;
      cur = 32'h0000_0000;
      val = 32'h0000_0000;
      go  = 1'b0;
      next_state = state;

      // capture address and data in either order, one outstanding write
      next_state.awReady = 1'b0;
      next_state.wReady  = 1'b0;
      if (s_axi_awvalid && state.awReady) begin
         next_state.awHeld = 1'b1;
         next_state.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state.wReady) begin
         next_state.wHeld = 1'b1;
         next_state.wData = s_axi_wdata;
         next_state.wStrb = s_axi_wstrb;
      end
      if (!next_state.awHeld && !state.bValid && !(s_axi_awvalid && state.awReady)) begin
         next_state.awReady = 1'b1;
      end
      if (!next_state.wHeld && !state.bValid && !(s_axi_wvalid && state.wReady)) begin
         next_state.wReady = 1'b1;
      end

      // write commit once both halves are held
      if (state.awHeld && state.wHeld && !state.bValid) begin
         next_state.awHeld = 1'b0;
         next_state.wHeld  = 1'b0;
         next_state.bValid = 1'b1;
         next_state.bResp  = mai_pkg::RESP_OKAY;
         case (state.awAddr)
            mai_pkg::OFF_CONTROL: begin
               cur = {state.doneSticky, 15'h0000, state.memAddr, 6'h00, state.op};
               val = merge(cur, state.wData, state.wStrb);
               next_state.op      = val[mai_pkg::CTL_OP_LSB +: 2];
               next_state.memAddr = val[mai_pkg::CTL_ADDR_LSB +: 8];
               go = state.wStrb[3] & state.wData[mai_pkg::CTL_GO_BIT];
            end
            mai_pkg::OFF_OPERAND: begin
               if (state.wStrb[0]) next_state.immediate = state.wData[7:0];
            end
            mai_pkg::OFF_WORKREG: begin
               if (state.wStrb[0]) next_state.workReg = state.wData[7:0];
            end
            mai_pkg::OFF_FLAGS: begin
               if (state.wStrb[0]) next_state.flags = state.wData[3:0];
            end
            mai_pkg::OFF_MEMWIN: begin
               if (state.wStrb[0]) begin
                  next_state.mem[memIdx*8 +: 8] = state.wData[7:0];
               end
            end
            default: begin
               next_state.bResp = mai_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (state.bValid && s_axi_bready) begin
         next_state.bValid = 1'b0;
      end

      // execute from registers as they stood before this write
      if (go) begin
         next_state.lastSum    = alu.sum;
         next_state.doneSticky = 1'b1;
         case (state.op)
            mai_pkg::OP_SUM_WITH_CARRY_TO_MEM: begin
               next_state.mem[memIdx*8 +: 8] = alu.sum;
            end
            default: begin
               next_state.workReg = alu.sum;
            end
         endcase
         // only these four bits change
         next_state.flags[mai_pkg::FLG_CARRY] = alu.carryOut;
         next_state.flags[mai_pkg::FLG_HALF]  = alu.halfOut;
         next_state.flags[mai_pkg::FLG_ZERO]  = alu.zeroOut;
         next_state.flags[mai_pkg::FLG_WRAP]  = alu.wrapOut;
      end

      // read channel, one outstanding read
      next_state.arReady = !state.rValid && !(s_axi_arvalid && state.arReady);
      if (s_axi_arvalid && state.arReady) begin
         next_state.rValid = 1'b1;
         next_state.rResp  = mai_pkg::RESP_OKAY;
         case (s_axi_araddr)
            mai_pkg::OFF_CONTROL: next_state.rData = {state.doneSticky, 15'h0000,
                                                      state.memAddr, 6'h00, state.op};
            mai_pkg::OFF_OPERAND: next_state.rData = {24'h000000, state.immediate};
            mai_pkg::OFF_WORKREG: next_state.rData = {24'h000000, state.workReg};
            mai_pkg::OFF_FLAGS:   next_state.rData = {28'h0000000, state.flags};
            mai_pkg::OFF_MEMWIN:  next_state.rData = {24'h000000, memByte};
            mai_pkg::OFF_LAST:    next_state.rData = {20'h00000, state.flags, state.lastSum};
            default: begin
               next_state.rData = 32'h0000_0000;
               next_state.rResp = mai_pkg::RESP_SLVERR;
            end
         endcase
      end else if (state.rValid && s_axi_rready) begin
         next_state.rValid = 1'b0;
      end
   end

   // single register stage for all state
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from state flops
   assign s_axi_awready = state.awReady;
   assign s_axi_wready  = state.wReady;
   assign s_axi_bvalid  = state.bValid;
   assign s_axi_bresp   = state.bResp;
   assign s_axi_arready = state.arReady;
   assign s_axi_rvalid  = state.rValid;
   assign s_axi_rresp   = state.rResp;
   assign s_axi_rdata   = state.rData;

endmodule : mai_addition

// *** mai_addition_sva.sv ***
// handshake checker for the addition datapath register port
`timescale 1ns/1ps
module mai_addition_sva (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ****************
   // response timing
   // ****************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // answers stay put until the master takes them
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   // one transfer each way at a time
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while answer pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
      else $error("bad write response code");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_read_done: cover property (s_axi_rvalid && s_axi_rready);
   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule : mai_addition_sva

bind mai_addition mai_addition_sva u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** mai_axi_master.sv ***
// register master model standing in for the core's decode side
`timescale 1ns/1ps
module mai_axi_master (
   input  wire logic        ref_clk,
   output logic [11:0]      awAddr,
   output logic             awValid,
   input  wire logic        awReady,
   output logic [31:0]      wData,
   output logic             wValid,
   input  wire logic        wReady,
   input  wire logic [1:0]  bResp,
   input  wire logic        bValid,
   output logic             bReady,
   output logic [11:0]      arAddr,
   output logic             arValid,
   input  wire logic        arReady,
   input  wire logic [31:0] rData,
   input  wire logic [1:0]  rResp,
   input  wire logic        rValid,
   output logic             rReady
);
   // idle payload is scrambled so nothing leans on stale values
   initial begin
      {awAddr, awValid, wData, wValid, bReady, arAddr, arValid, rReady} = '0;
   end
   // handshakes and answers are taken at the rising edge where they are sampled
   task automatic write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'h0;
      r   = 2'h0;
      @(posedge ref_clk);
      awAddr  <= a;
      wData   <= d;
      awValid <= 1'h1;
      wValid  <= 1'h1;
      bReady  <= 1'h1;
      while (!got) begin
         @(posedge ref_clk);
         got = bValid;
         r   = bResp;
         if (awValid && awReady) begin
            awValid <= 1'h0;
            awAddr  <= ~a;
         end
         if (wValid && wReady) begin
            wValid <= 1'h0;
            wData  <= ~d;
         end
      end
      bReady <= 1'h0;
   endtask : write
   task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'h0;
      d   = 32'h0;
      r   = 2'h0;
      @(posedge ref_clk);
      arAddr  <= a;
      arValid <= 1'h1;
      rReady  <= 1'h1;
      while (!got) begin
         @(posedge ref_clk);
         got = rValid;
         d   = rData;
         r   = rResp;
         if (arValid && arReady) begin
            arValid <= 1'h0;
            arAddr  <= ~a;
         end
      end
      rReady <= 1'h0;
   endtask : read
endmodule : mai_axi_master

// *** mai_addition_tb_top.sv ***
// self-checking bench for the addition datapath
`timescale 1ns/1ps
module mai_addition_tb_top;
   logic        ref_clk, rst_n, awValid, awReady, wValid, wReady, bValid, bReady;
   logic        arValid, arReady, rValid, rReady;
   logic [11:0] awAddr, arAddr;
   logic [31:0] wData, rData, rd;
   logic [1:0]  bResp, rResp, rsp, op;
   logic [7:0]  w, memIn, imm, addr, opd;
   logic [8:0]  s9;
   logic [3:0]  flg;
   logic        cin, ci, toMem;
   int          fail_count = 0;
   int          comparisons = 0;
   // op, work, memory, immediate, carry in
   logic [26:0] tbl [5] = '{{2'h0, 8'h7f, 8'h00, 8'h00, 1'h1}, {2'h1, 8'hff, 8'h00, 8'h00, 1'h1},
      {2'h2, 8'h80, 8'h80, 8'h00, 1'h1}, {2'h3, 8'h08, 8'h55, 8'h08, 1'h1},
      {2'h1, 8'h12, 8'h34, 8'h00, 1'h0}};
   mai_addition dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady));
   mai_axi_master m (.ref_clk(ref_clk), .awAddr(awAddr), .awValid(awValid), .awReady(awReady),
      .wData(wData), .wValid(wValid), .wReady(wReady), .bResp(bResp), .bValid(bValid),
      .bReady(bReady), .arAddr(arAddr), .arValid(arValid), .arReady(arReady), .rData(rData),
      .rResp(rResp), .rValid(rValid), .rReady(rReady));
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] want);
      logic [1:0] r;
      m.write(a, d, r);
      check(32'(r), 32'(want));
   endtask : wr
   task automatic wrap_up;
      if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // hang guard, far beyond the sixty or so transfers below
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      rst_n = 1'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (5) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         {op, w, memIn, imm, cin} = tbl[i];
         addr = 8'(15 - 3 * i);
         wr(mai_pkg::OFF_CONTROL, {16'h0, addr, 6'h0, op}, mai_pkg::RESP_OKAY);
         wr(mai_pkg::OFF_MEMWIN, {24'h0, memIn}, mai_pkg::RESP_OKAY);
         wr(mai_pkg::OFF_WORKREG, {24'h0, w}, mai_pkg::RESP_OKAY);
         wr(mai_pkg::OFF_FLAGS, 32'(cin) << mai_pkg::FLG_CARRY, mai_pkg::RESP_OKAY);
         wr(mai_pkg::OFF_OPERAND, {24'h0, imm}, mai_pkg::RESP_OKAY);
         wr(mai_pkg::OFF_CONTROL, {1'h1, 15'h0, addr, 6'h0, op}, mai_pkg::RESP_OKAY);
         rd = 32'h0;
         for (int k = 0; k < 20 && rd[31] !== 1'h1; k++) m.read(mai_pkg::OFF_CONTROL, rd, rsp);
         check(32'(rd[31]), 32'h1);
         // reference sum: carry only for the two carry forms
         toMem = (op == mai_pkg::OP_SUM_WITH_CARRY_TO_MEM);
         ci = (toMem || op == mai_pkg::OP_SUM_CARRY_TO_WORK) & cin;
         opd = (op == mai_pkg::OP_SUM_IMM_TO_WORK) ? imm : memIn;
         s9 = {1'h0, w} + {1'h0, opd} + 9'(ci);
         flg = 4'h0;
         flg[mai_pkg::FLG_CARRY] = s9[8];
         flg[mai_pkg::FLG_HALF] = ({1'h0, w[3:0]} + {1'h0, opd[3:0]} + 5'(ci)) > 5'h0f;
         flg[mai_pkg::FLG_ZERO] = (s9[7:0] == 8'h00);
         flg[mai_pkg::FLG_WRAP] = (w[7] == opd[7]) && (s9[7] != w[7]);
         m.read(mai_pkg::OFF_WORKREG, rd, rsp);
         check(rd & 32'hff, {24'h0, toMem ? w : s9[7:0]});
         check(32'(rsp), 32'(mai_pkg::RESP_OKAY));
         m.read(mai_pkg::OFF_MEMWIN, rd, rsp);
         check(rd & 32'hff, {24'h0, toMem ? s9[7:0] : memIn});
         m.read(mai_pkg::OFF_FLAGS, rd, rsp);
         check(rd & 32'hf, {28'h0, flg});
         m.read(mai_pkg::OFF_LAST, rd, rsp);
         check(rd & 32'hfff, {20'h0, flg, s9[7:0]});
      end
      // unmapped places are refused both ways
      m.read(12'h018, rd, rsp);
      check(32'(rsp), 32'(mai_pkg::RESP_SLVERR));
      wr(12'h01c, 32'h0000_00ff, mai_pkg::RESP_SLVERR);
      wrap_up();
   end
endmodule : mai_addition_tb_top
